// File: hw/asc_pkg.sv
// Package with register map, field positions, reset values and timing counts.
package asc_pkg;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] ASC_OFS_CONTROL_A = 8'h00;
    localparam logic [7:0] ASC_OFS_CONTROL_B = 8'h04;
    localparam logic [7:0] ASC_OFS_REFERENCE = 8'h08;
    localparam logic [7:0] ASC_OFS_RESULT_HIGH = 8'h0C;
    localparam logic [7:0] ASC_OFS_RESULT_LOW = 8'h10;
    localparam logic [7:0] ASC_OFS_PIN_ANALOG = 8'h14;
    localparam logic [7:0] ASC_OFS_STATUS = 8'h18;

    // Field positions of conv_control_a.
    localparam int ASC_A_START_BIT = 7;
    localparam int ASC_A_BUSY_BIT = 6;
    localparam int ASC_A_ENABLE_BIT = 5;
    localparam int ASC_A_FORMAT_BIT = 4;
    localparam int ASC_A_CHAN_LSB = 0;

    // Field positions of conv_control_b and conv_reference_control.
    localparam int ASC_B_INSRC_LSB = 4;
    localparam int ASC_B_CLKDIV_LSB = 0;
    localparam int ASC_REF_SEL_LSB = 2;

    // Reset values.
    localparam logic [3:0] ASC_CHAN_RESET = 4'h0;
    localparam logic [3:0] ASC_INSRC_RESET = 4'h0;
    localparam logic [2:0] ASC_CLKDIV_RESET = 3'h0;
    localparam logic [1:0] ASC_REF_RESET = 2'h0;
    localparam logic [11:0] ASC_RESULT_RESET = 12'h000;
    localparam logic [10:0] ASC_PIN_RESET = 11'h000;

    // Reference source codes.
    localparam logic [1:0] ASC_REF_SUPPLY = 2'h0;
    localparam logic [1:0] ASC_REF_EXT_PIN = 2'h1;

    // Conversion length in conversion clock periods.
    localparam logic [4:0] ASC_SAMPLE_TICKS = 5'h04;
    localparam logic [4:0] ASC_CONVERT_TICKS = 5'h0C;
    localparam logic [4:0] ASC_TOTAL_TICKS = 5'h10;

    // Power settling delay after enable, as a time and as a cycle count.
    localparam int ASC_CLK_PERIOD_NS = 10;
    localparam int ASC_SETTLE_TIME_NS = 1000;
    localparam int ASC_SETTLE_CYCLES =
        (ASC_SETTLE_TIME_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;

    // Number of analog pins, indexed by channel number.
    localparam int ASC_NUM_PINS = 11;

    // Internal source one-hot lanes.
    localparam int ASC_INT_SUPPLY = 0;
    localparam int ASC_INT_SUPPLY_HALF = 1;
    localparam int ASC_INT_SUPPLY_QUARTER = 2;
    localparam int ASC_INT_AMP = 3;
    localparam int ASC_INT_AMP_HALF = 4;
    localparam int ASC_INT_AMP_QUARTER = 5;
    localparam int ASC_INT_OPAMP = 6;
    localparam int ASC_INT_GROUND = 7;

    // Sequencer states.
    typedef enum logic [2:0] {
        ASC_ST_IDLE = 3'b001,
        ASC_ST_SAMPLE = 3'b010,
        ASC_ST_CONVERT = 3'b100
    } asc_state_type;

endpackage

// File: hw/asc_clock_divider.sv
// Power-of-two conversion clock tick generator.
`timescale 1ns/100ps
`default_nettype none
module asc_clock_divider
    import asc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] div_sel,
    input wire logic restart,
    output logic tick
);

    typedef struct packed {
        logic [6:0] count;
        logic tick;
    } asc_div_state_type;

    asc_div_state_type s_reg;
    asc_div_state_type s_next;
    logic [6:0] limit;

    // One tick every 2**div_sel system clocks; restart aligns the phase.
    always_comb begin
        s_next = s_reg;
        limit = 7'((8'h01 << div_sel) - 8'h01);
        if (restart) begin
            s_next.count = 7'h00;
            s_next.tick = 1'b0;
        end else if (s_reg.count >= limit) begin
            s_next.count = 7'h00;
            s_next.tick = 1'b1;
        end else begin
            s_next.count = s_reg.count + 7'h01;
            s_next.tick = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

endmodule
`default_nettype wire

// File: hw/asc_sequence_control.sv
// Converter sequence control with AHB-Lite registers and analog routing.
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module asc_sequence_control
    import asc_pkg::*;
#(
    parameter int SETTLE_CYCLES = ASC_SETTLE_CYCLES
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [11:0] core_result,
    input wire logic [10:0] port_pullup_cfg,
    input wire logic [10:0] port_output_en_cfg,
    output logic conv_power_enable,
    output logic conv_sample_active,
    output logic conv_convert_active,
    output logic conv_clock_tick,
    output logic conv_irq_request,
    output logic ref_from_supply,
    output logic ref_from_ext_pin,
    output logic ref_from_amplifier,
    output logic [10:0] external_analog_channel,
    output logic [7:0] internal_source_sel,
    output logic [10:0] pin_digital_enable,
    output logic [10:0] pin_pullup_enable,
    output logic [10:0] pin_output_enable
);

    typedef struct packed {
        asc_state_type state;
        logic start_bit;
        logic busy;
        logic enable;
        logic format;
        logic [3:0] chan;
        logic [3:0] insrc;
        logic [2:0] clkdiv;
        logic [1:0] refsel;
        logic [11:0] result;
        logic [4:0] ticks;
        logic [15:0] settle_cnt;
        logic settled;
        logic [10:0] analog_mask;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic irq;
        logic sample_out;
        logic convert_out;
        logic tick_out;
        logic ref_supply;
        logic ref_pin;
        logic ref_amp;
        logic [10:0] chan_out;
        logic [7:0] int_out;
        logic [10:0] dig_out;
        logic [10:0] pull_out;
        logic [10:0] oe_out;
    } asc_state_reg_type;

    asc_state_reg_type s_reg;
    asc_state_reg_type s_next;
    logic div_tick;
    logic div_restart;
    logic trigger;
    logic [7:0] new_byte;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // Codes 0x01, 0x10, 0x11 and 10xx route an internal signal.
    function automatic logic is_internal(input logic [3:0] src);
        is_internal = (src[1:0] != 2'h0) && !src[3]
            || (src[3:2] == 2'h2);
    endfunction

    // One-hot external channel; reserved and missing codes float.
    function automatic logic [10:0] chan_decode(input logic [3:0] src,
                                                input logic [3:0] ch);
        chan_decode = 11'h000;
        if (!is_internal(src) && ch != 4'h0 && ch != 4'h8
            && ch <= 4'hA) begin
            chan_decode[ch] = 1'b1;
        end
    endfunction

    // One-hot internal source for the analog multiplexer.
    function automatic logic [7:0] int_decode(input logic [3:0] src);
        int_decode = 8'h00;
        unique case (src)
            4'h1: int_decode[ASC_INT_SUPPLY] = 1'b1;
            4'h2: int_decode[ASC_INT_SUPPLY_HALF] = 1'b1;
            4'h3: int_decode[ASC_INT_SUPPLY_QUARTER] = 1'b1;
            4'h5: int_decode[ASC_INT_AMP] = 1'b1;
            4'h6: int_decode[ASC_INT_AMP_HALF] = 1'b1;
            4'h7: int_decode[ASC_INT_AMP_QUARTER] = 1'b1;
            4'h8: int_decode[ASC_INT_OPAMP] = 1'b1;
            4'h9, 4'hA, 4'hB: int_decode[ASC_INT_GROUND] = 1'b1;
            default: int_decode = 8'h00;
        endcase
    endfunction

    // Justified result bytes; the format applies at read time.
    function automatic logic [7:0] result_byte(input logic [11:0] r,
                                               input logic fmt,
                                               input logic high);
        if (!fmt) begin
            result_byte = high ? r[11:4] : {r[3:0], 4'h0};
        end else begin
            result_byte = high ? {4'h0, r[11:8]} : r[7:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock divider.

    asc_clock_divider asc_clock_divider_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .div_sel(s_reg.clkdiv),
        .restart(div_restart),
        .tick(div_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, sequencer and routing.

    always_comb begin
        s_next = s_reg;
        trigger = 1'b0;
        div_restart = 1'b0;
        new_byte = hwdata[7:0];
        s_next.irq = 1'b0;

        // Address phase: latch writes, prepare read data for the data phase.
        s_next.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_next.wr_pend = hwrite;
            s_next.wr_addr = haddr[7:0];
            s_next.rdata = 32'h0000_0000;
            if (!hwrite) begin
                unique case (haddr[7:0])
                    ASC_OFS_CONTROL_A: s_next.rdata[7:0] =
                        {s_reg.start_bit, s_reg.busy, s_reg.enable,
                         s_reg.format, s_reg.chan};
                    ASC_OFS_CONTROL_B: s_next.rdata[7:0] =
                        {s_reg.insrc, 1'b0, s_reg.clkdiv};
                    ASC_OFS_REFERENCE: s_next.rdata[7:0] =
                        {4'h0, s_reg.refsel, 2'h0};
                    ASC_OFS_RESULT_HIGH: s_next.rdata[7:0] =
                        result_byte(s_reg.result, s_reg.format, 1'b1);
                    ASC_OFS_RESULT_LOW: s_next.rdata[7:0] =
                        result_byte(s_reg.result, s_reg.format, 1'b0);
                    ASC_OFS_PIN_ANALOG: s_next.rdata[10:0] =
                        s_reg.analog_mask;
                    ASC_OFS_STATUS: s_next.rdata[4:0] =
                        {s_reg.settled, s_reg.busy, s_reg.state};
                    default: s_next.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Data phase of a write; busy is read only and ignores writes.
        if (s_reg.wr_pend) begin
            unique case (s_reg.wr_addr)
                ASC_OFS_CONTROL_A: begin
                    s_next.start_bit = new_byte[ASC_A_START_BIT];
                    s_next.enable = new_byte[ASC_A_ENABLE_BIT];
                    s_next.format = new_byte[ASC_A_FORMAT_BIT];
                    s_next.chan = new_byte[ASC_A_CHAN_LSB +: 4];
                    // Falling start after a high start arms a conversion.
                    trigger = s_reg.start_bit
                        && !new_byte[ASC_A_START_BIT];
                end
                ASC_OFS_CONTROL_B: begin
                    s_next.insrc = new_byte[ASC_B_INSRC_LSB +: 4];
                    s_next.clkdiv = new_byte[ASC_B_CLKDIV_LSB +: 3];
                end
                ASC_OFS_REFERENCE: begin
                    s_next.refsel = new_byte[ASC_REF_SEL_LSB +: 2];
                end
                ASC_OFS_PIN_ANALOG: begin
                    s_next.analog_mask = hwdata[10:0];
                end
                default: begin
                end
            endcase
        end

        // Settling counter restarts whenever the converter is powered down.
        if (!s_reg.enable) begin
            s_next.settle_cnt = 16'h0000;
            s_next.settled = 1'b0;
        end else if (s_reg.settle_cnt >= 16'(SETTLE_CYCLES - 1)) begin
            s_next.settled = 1'b1;
        end else begin
            s_next.settle_cnt = s_reg.settle_cnt + 16'h0001;
        end

        // A start before settling or during a conversion is dropped,
        // because restarting would corrupt the sample in flight.
        unique case (s_reg.state)
            ASC_ST_IDLE: begin
                if (trigger && s_reg.enable && s_reg.settled) begin
                    s_next.state = ASC_ST_SAMPLE;
                    s_next.busy = 1'b1;
                    s_next.ticks = 5'h00;
                    div_restart = 1'b1;
                end
            end
            ASC_ST_SAMPLE: begin
                if (div_tick) begin
                    s_next.ticks = s_reg.ticks + 5'h01;
                    if (s_reg.ticks == ASC_SAMPLE_TICKS - 5'h01) begin
                        s_next.state = ASC_ST_CONVERT;
                    end
                end
            end
            ASC_ST_CONVERT: begin
                if (div_tick) begin
                    s_next.ticks = s_reg.ticks + 5'h01;
                    if (s_reg.ticks == ASC_TOTAL_TICKS - 5'h01) begin
                        s_next.state = ASC_ST_IDLE;
                        s_next.busy = 1'b0;
                        s_next.result = core_result;
                        s_next.irq = 1'b1;
                    end
                end
            end
        endcase

        // Power-down aborts a conversion that is not finishing in the same cycle and leaves the result untouched.
        if (!s_next.enable && s_next.state != ASC_ST_IDLE) begin
            s_next.state = ASC_ST_IDLE;
            s_next.busy = 1'b0;
            s_next.irq = 1'b0;
            s_next.result = s_reg.result;
        end

        // Registered analog routing and pin overrides.
        s_next.sample_out = (s_next.state == ASC_ST_SAMPLE);
        s_next.convert_out = (s_next.state == ASC_ST_CONVERT);
        s_next.tick_out = div_tick && s_reg.enable;
        s_next.ref_supply = (s_reg.refsel == ASC_REF_SUPPLY);
        s_next.ref_pin = (s_reg.refsel == ASC_REF_EXT_PIN);
        s_next.ref_amp = s_reg.refsel[1];
        s_next.chan_out = chan_decode(s_reg.insrc, s_reg.chan);
        s_next.int_out = int_decode(s_reg.insrc);
        s_next.dig_out = ~s_reg.analog_mask;
        s_next.pull_out = port_pullup_cfg & ~s_reg.analog_mask;
        s_next.oe_out = port_output_en_cfg & ~s_reg.analog_mask;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; control fields reset to zero, state to IDLE, ref_supply and dig_out to ones.

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.state <= ASC_ST_IDLE;
            s_reg.chan <= ASC_CHAN_RESET;
            s_reg.insrc <= ASC_INSRC_RESET;
            s_reg.clkdiv <= ASC_CLKDIV_RESET;
            s_reg.refsel <= ASC_REF_RESET;
            s_reg.result <= ASC_RESULT_RESET;
            s_reg.analog_mask <= ASC_PIN_RESET;
            s_reg.ref_supply <= 1'b1;
            s_reg.dig_out <= 11'h7FF;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register except hreadyout from ready_reg.

    // The slave never stalls, so ready is the constant reset value of one.
    logic ready_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_reg <= 1'b1;
        end else begin
            ready_reg <= 1'b1;
        end
    end

    assign hreadyout = ready_reg;
    assign hresp = s_reg.irq & 1'b0;
    assign hrdata = s_reg.rdata;
    assign conv_power_enable = s_reg.enable;
    assign conv_sample_active = s_reg.sample_out;
    assign conv_convert_active = s_reg.convert_out;
    assign conv_clock_tick = s_reg.tick_out;
    assign conv_irq_request = s_reg.irq;
    assign ref_from_supply = s_reg.ref_supply;
    assign ref_from_ext_pin = s_reg.ref_pin;
    assign ref_from_amplifier = s_reg.ref_amp;
    assign external_analog_channel = s_reg.chan_out;
    assign internal_source_sel = s_reg.int_out;
    assign pin_digital_enable = s_reg.dig_out;
    assign pin_pullup_enable = s_reg.pull_out;
    assign pin_output_enable = s_reg.oe_out;

endmodule
`default_nettype wire

// File: testbench/asc_sequence_control_props.sv
// Checker module of port relations for the converter sequence control.
`timescale 1ns/100ps
`default_nettype none
module asc_props_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic conv_power_enable,
    input wire logic conv_sample_active,
    input wire logic conv_convert_active,
    input wire logic conv_clock_tick,
    input wire logic conv_irq_request,
    input wire logic ref_from_supply,
    input wire logic ref_from_ext_pin,
    input wire logic ref_from_amplifier,
    input wire logic [10:0] external_analog_channel,
    input wire logic [7:0] internal_source_sel,
    input wire logic [10:0] pin_digital_enable,
    input wire logic [10:0] pin_pullup_enable,
    input wire logic [10:0] pin_output_enable,
    input wire logic [10:0] port_pullup_cfg,
    input wire logic [10:0] port_output_en_cfg
);
    logic [4:0] samp_cnt_reg;
    logic [4:0] conv_cnt_reg;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Ticks seen in each phase; a phase that runs long shows up as overflow.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_cnt_reg <= 5'h00;
            conv_cnt_reg <= 5'h00;
        end else begin
            samp_cnt_reg <= !conv_sample_active ? 5'h00 :
                samp_cnt_reg + 5'(conv_clock_tick);
            conv_cnt_reg <= !conv_convert_active ? 5'h00 :
                conv_cnt_reg + 5'(conv_clock_tick);
        end
    end

    sequence s_sample_end;
        $fell(conv_sample_active) && conv_power_enable;
    endsequence
    sequence s_done;
        conv_irq_request;
    endsequence
    sequence s_convert_end;
        $fell(conv_convert_active) && conv_power_enable;
    endsequence

    a_ref_onehot: assert property ($onehot({ref_from_supply,
        ref_from_ext_pin, ref_from_amplifier})) else $error("ref not onehot");
    a_amp_no_pin: assert property (
        ref_from_amplifier |-> !ref_from_ext_pin)
        else $error("ext ref pin left on");
    a_int_no_ext: assert property (|internal_source_sel |->
        external_analog_channel == 11'h000) else $error("ext path on");
    a_ext_holes: assert property (!external_analog_channel[0] &&
        !external_analog_channel[8]) else $error("reserved channel on");
    a_pullup_off: assert property ($past(hresetn) |->
        pin_pullup_enable == ($past(port_pullup_cfg) & pin_digital_enable))
        else $error("pull-up not removed");
    a_dir_override: assert property ($past(hresetn) |->
        pin_output_enable == ($past(port_output_en_cfg) & pin_digital_enable))
        else $error("direction not overridden");
    a_phase_order: assert property (
        s_sample_end |-> conv_convert_active)
        else $error("convert phase missing");
    a_sample_len: assert property (samp_cnt_reg <= 5'h04)
        else $error("sample phase too long");
    a_convert_len: assert property (conv_cnt_reg <= 5'h0C)
        else $error("convert phase too long");
    a_sample_min: assert property (
        s_sample_end |-> samp_cnt_reg >= 5'h03)
        else $error("sample phase too short");
    a_convert_full: assert property (
        s_convert_end |-> conv_cnt_reg == 5'h0C)
        else $error("convert phase not twelve ticks");
    a_irq_at_end: assert property (s_done |->
        $past(conv_convert_active) && !conv_convert_active)
        else $error("irq not at completion");
    a_irq_pulse: assert property (
        conv_irq_request |=> !conv_irq_request)
        else $error("irq longer than a cycle");
    a_powered: assert property (
        conv_sample_active || conv_convert_active |-> conv_power_enable)
        else $error("conversion while off");
endmodule

bind asc_sequence_control asc_props_checker asc_props_checker_inst (
    .hclk(hclk), .hresetn(hresetn), .conv_power_enable(conv_power_enable),
    .conv_sample_active(conv_sample_active),
    .conv_convert_active(conv_convert_active),
    .conv_clock_tick(conv_clock_tick), .conv_irq_request(conv_irq_request),
    .ref_from_supply(ref_from_supply), .ref_from_ext_pin(ref_from_ext_pin),
    .ref_from_amplifier(ref_from_amplifier),
    .external_analog_channel(external_analog_channel),
    .internal_source_sel(internal_source_sel),
    .pin_digital_enable(pin_digital_enable),
    .pin_pullup_enable(pin_pullup_enable),
    .pin_output_enable(pin_output_enable),
    .port_pullup_cfg(port_pullup_cfg),
    .port_output_en_cfg(port_output_en_cfg)
);
`default_nettype wire

// File: testbench/tb_asc_sequence_control.sv
// Self-checking testbench of the converter sequence control block.
`timescale 1ns/100ps
`default_nettype none
module tb_asc_sequence_control;
    import asc_pkg::*;
    localparam int SETTLE = 12;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic rd_phase = 1'b0, f;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [11:0] core_result = 12'h000, res, last;
    logic [10:0] pu_cfg = 11'h000, oe_cfg = 11'h000, msk, ext_ch, dig, pu, oe;
    logic [3:0] ch;
    logic [7:0] isrc;
    logic hreadyout, hresp, pwr, samp, conv, tick, irq, r_sup, r_ext, r_amp;
    logic [31:0] exp_q[$];
    int bad_count = 0, total_checks = 0, irq_n = 0, gap = 0, since = 0;
    int i, k, n0;

    always #5 hclk = ~hclk;

    asc_sequence_control #(.SETTLE_CYCLES(SETTLE)) asc_sequence_control_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .core_result(core_result),
        .port_pullup_cfg(pu_cfg), .port_output_en_cfg(oe_cfg),
        .conv_power_enable(pwr), .conv_sample_active(samp),
        .conv_convert_active(conv), .conv_clock_tick(tick),
        .conv_irq_request(irq), .ref_from_supply(r_sup),
        .ref_from_ext_pin(r_ext), .ref_from_amplifier(r_amp),
        .external_analog_channel(ext_ch), .internal_source_sel(isrc),
        .pin_digital_enable(dig), .pin_pullup_enable(pu),
        .pin_output_enable(oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single-word transfer; a read's d is the value the monitor expects.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        rd_phase <= !wr;
        if (wr) hwdata <= d;
        else exp_q.push_back(d);
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_phase <= 1'b0;
    endtask

    // Internal lane expected for each input source code.
    function automatic logic [7:0] lane(input logic [3:0] s);
        case (s)
            4'h1: return 8'h01;
            4'h2: return 8'h02;
            4'h3: return 8'h04;
            4'h5: return 8'h08;
            4'h6: return 8'h10;
            4'h7: return 8'h20;
            4'h8: return 8'h40;
            4'h9, 4'hA, 4'hB: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [31:0] fmt_res(input logic [11:0] r,
        input logic fm, input logic h);
        if (h) return fm ? {28'h0, r[11:8]} : {24'h0, r[11:4]};
        return fm ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Read data are taken at the end of the data phase; ticks are timed here.
    always @(posedge hclk) begin
        if (rd_phase && hreadyout === 1'b1) chk(hrdata, exp_q.pop_front());
        if (rd_phase) chk(32'({hreadyout, hresp}), 32'h2);
        if (irq === 1'b1) irq_n++;
        since++;
        if (tick === 1'b1) begin
            gap = since;
            since = 0;
        end
    end

    // A hung wait ends here so the verdict still prints once.
    initial begin
        repeat (50000) @(posedge hclk);
        bad_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        void'($urandom(72012));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(32'({r_amp, r_ext, r_sup}), 32'h1);
        chk(32'(dig), 32'h7FF);
        bus(0, ASC_OFS_CONTROL_A, 32'h0);
        bus(0, ASC_OFS_CONTROL_B, 32'h0);
        bus(0, ASC_OFS_REFERENCE, 32'h0);
        bus(0, ASC_OFS_RESULT_HIGH, 32'h0);
        bus(0, ASC_OFS_STATUS, 32'h01);
        bus(0, 8'h1C, 32'h0);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            bus(1, ASC_OFS_REFERENCE, 32'hF3 | 32'(i << 2));
            bus(0, ASC_OFS_REFERENCE, 32'(i << 2));
            @(posedge hclk);
            chk(32'({r_amp, r_ext, r_sup}),
                i[1] ? 32'h4 : (i[0] ? 32'h2 : 32'h1));
        end
        $display("test reference done");
        // Every input source code, with random channel, pins and port setup.
        for (i = 0; i < 16; i++) begin
            ch = 4'($urandom);
            msk = 11'($urandom);
            pu_cfg <= 11'($urandom);
            oe_cfg <= 11'($urandom);
            bus(1, ASC_OFS_CONTROL_B, {24'h0, 4'(i), 4'hF});
            bus(0, ASC_OFS_CONTROL_B, {24'h0, 4'(i), 4'h7});
            bus(1, ASC_OFS_CONTROL_A, {28'h0, ch});
            bus(1, ASC_OFS_PIN_ANALOG, {21'h0, msk});
            repeat (2) @(posedge hclk);
            chk(32'(isrc), 32'(lane(4'(i))));
            chk(32'(ext_ch),
                (lane(4'(i)) == 8'h00 && ch != 4'h0 && ch != 4'h8 &&
                ch < 4'hB) ? 32'h1 << ch : 32'h0);
            chk(32'(dig), {21'h0, ~msk});
            chk(32'(pu), {21'h0, pu_cfg & ~msk});
            chk(32'(oe), {21'h0, oe_cfg & ~msk});
        end
        $display("test routing done");
        // A start before the power has settled is dropped.
        bus(1, ASC_OFS_CONTROL_A, 32'h20);
        bus(1, ASC_OFS_CONTROL_A, 32'hA0);
        bus(1, ASC_OFS_CONTROL_A, 32'h20);
        bus(0, ASC_OFS_CONTROL_A, 32'h20);
        repeat (SETTLE + 4) @(posedge hclk);
        bus(0, ASC_OFS_STATUS, 32'h11);
        $display("test settle done");
        // One conversion at each clock division, both result formats.
        for (i = 0; i < 8; i++) begin
            f = i[0];
            res = 12'($urandom);
            core_result <= res;
            bus(1, ASC_OFS_CONTROL_B, 32'(i));
            bus(1, ASC_OFS_CONTROL_A, 32'h20 | 32'(f) << 4);
            bus(1, ASC_OFS_CONTROL_A, 32'hA0 | 32'(f) << 4);
            bus(1, ASC_OFS_CONTROL_A, 32'h20 | 32'(f) << 4);
            bus(0, ASC_OFS_CONTROL_A, 32'h60 | 32'(f) << 4);
            n0 = irq_n;
            for (k = 0; k < (64 << i) && irq_n == n0; k++) @(posedge hclk);
            @(posedge hclk);
            chk(32'(irq_n - n0), 32'h1);
            chk(32'(gap), 32'h1 << i);
            bus(0, ASC_OFS_CONTROL_A, 32'h20 | 32'(f) << 4);
            bus(0, ASC_OFS_RESULT_HIGH, fmt_res(res, f, 1'b1));
            bus(0, ASC_OFS_RESULT_LOW, fmt_res(res, f, 1'b0));
            last = res;
        end
        $display("test conversion done");
        // Dropping the enable mid-conversion aborts it and keeps the result.
        // Division 6 keeps the conversion clock period at 640 ns here.
        core_result <= ~last;
        bus(1, ASC_OFS_CONTROL_B, 32'h6);
        bus(1, ASC_OFS_CONTROL_A, 32'hA0);
        bus(1, ASC_OFS_CONTROL_A, 32'h20);
        repeat (400) @(posedge hclk);
        bus(1, ASC_OFS_CONTROL_A, 32'h00);
        n0 = irq_n;
        repeat (1200) @(posedge hclk);
        chk(32'(irq_n - n0), 32'h0);
        bus(0, ASC_OFS_CONTROL_A, 32'h00);
        bus(0, ASC_OFS_RESULT_HIGH, fmt_res(last, 1'b0, 1'b1));
        bus(0, ASC_OFS_RESULT_LOW, fmt_res(last, 1'b0, 1'b0));
        $display("test abort done");
        close_out();
    end
endmodule
`default_nettype wire
